// ---- core/phycl_top.sv ----
// How it works
// - carrier goes to the carrier pin in MII, carrier/valid pin in RMII
// - repeater or full duplex: carrier from receive only, else either direction
// - carrier starts on two non-adjacent zeros within ten raw line bits
// - ten ones before a start pair end the carrier
// - after start pair, carrier holds until an end or idle symbol
// - end symbol without follow-up, or idle then data, brings carrier back
// - collision asserted while transmit and receive overlap
// - collision is on the system clock; the MAC synchronises it
// - full duplex holds collision low unless collision test is set
// - collision test mirrors transmit enable within a few cycles
// - speed selects 100 or 10 link result for status bit and indicator
// - valid line enters ready, then up on negotiation grant
// - negotiation off: straight from settle to up, skipping ready
// - wait 330 us settle before ready
// - valid lost in any state: link down at once
// - 10BASE-T link comes from the 10 Mbps receiver
// - near loopback returns transmit data on receive outputs
// - near loopback: collision only under test, transmitters powered down
// - remote loopback resends line data and isolates MAC outputs
// - remote loopback only honoured in RMII mode
// - registers at clause 22 indices, byte address four times index
// - isolate ignores transmit inputs but registers still answer
`default_nettype none
module phycl_top
    import phycl_pkg::*;
#(
    parameter int SETTLE_CYC = SETTLE_CYCLES
) (
    // system
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // mac transmit side
    input wire logic txEn,
    input wire logic [3:0] txd,
    // mac receive side
    output logic crs,
    output logic crsDv,
    output logic col,
    output logic rxDv,
    output logic [3:0] rxd,
    // line receive stream
    input wire logic lineClk,
    input wire logic lineRxBit,
    input wire logic [3:0] lineRxNibble,
    // line transmit side
    output logic lineTxBit,
    output logic lineTxEn,
    output logic txPowerDown,
    // link sources
    input wire logic signalValid,
    input wire logic anGrant,
    input wire logic link10,
    output logic linkIndicatorOutput
);

    function automatic logic twoApartZeros(input logic [9:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 10; i++) begin
            for (int j = i + 2; j < 10; j++) begin
                if (!w[i] && !w[j]) begin
                    hit = 1'b1;
                end
            end
        end
        return hit;
    endfunction

    // two-stage synchronisers for all foreign inputs
    logic [1:0] lineClkS1_ff;
    logic lineClkPrev_ff;
    logic [1:0] rxBitS1_ff;
    logic [8:0] syncS1_ff, syncS2_ff;
    logic [3:0] nibS1_ff, nibS2_ff;
    logic rxBitS;

    always_ff @(posedge clk) begin
        if (reset) begin
            lineClkS1_ff <= 2'h0;
            lineClkPrev_ff <= 1'b0;
            rxBitS1_ff <= 2'h0;
            syncS1_ff <= 9'h000;
            syncS2_ff <= 9'h000;
            nibS1_ff <= 4'h0;
            nibS2_ff <= 4'h0;
        end else begin
            lineClkS1_ff <= {lineClkS1_ff[0], lineClk};
            lineClkPrev_ff <= lineClkS1_ff[1];
            rxBitS1_ff <= {rxBitS1_ff[0], lineRxBit};
            syncS1_ff <= {txEn, txd, signalValid, anGrant, link10, 1'b0};
            syncS2_ff <= syncS1_ff;
            nibS1_ff <= lineRxNibble;
            nibS2_ff <= nibS1_ff;
        end
    end

    logic lineEdge;
    logic txEnS, validS, grantS, link10S;
    logic [3:0] txdS;
    assign lineEdge = lineClkS1_ff[1] && !lineClkPrev_ff;
    assign rxBitS = rxBitS1_ff[1];
    assign txEnS = syncS2_ff[8];
    assign txdS = syncS2_ff[7:4];
    assign validS = syncS2_ff[3];
    assign grantS = syncS2_ff[2];
    assign link10S = syncS2_ff[1];

    // register file
    logic [15:0] ctrl_ff, mode_ff;
    logic accessDone, isCtrl, isStat, isMode, mapped;
    logic [5:0] regIdx;
    assign accessDone = psel && penable && pready;
    assign regIdx = paddr[7:2];

    always_comb begin
        isCtrl = 1'b0;
        isStat = 1'b0;
        isMode = 1'b0;
        if (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0) begin
            isCtrl = 1'b0;
        end else if (regIdx == IDX_BASIC_CTRL) begin
            isCtrl = 1'b1;
        end else if (regIdx == IDX_BASIC_STAT) begin
            isStat = 1'b1;
        end else if (regIdx == IDX_MODE_CTRL) begin
            isMode = 1'b1;
        end
        mapped = isCtrl || isStat || isMode;
    end

    logic softReset;
    assign softReset = accessDone && pwrite && isCtrl && pwdata[CTRL_SOFT_RESET];

    always_ff @(posedge clk) begin
        if (reset || softReset) begin
            ctrl_ff <= CTRL_RESET_VAL;
            mode_ff <= MODE_RESET_VAL;
        end else if (accessDone && pwrite && isCtrl) begin
            ctrl_ff <= pwdata[15:0] & CTRL_WR_MASK;
        end else if (accessDone && pwrite && isMode) begin
            mode_ff <= pwdata[15:0] & MODE_WR_MASK;
        end
    end

    logic nearLb, remoteLb, isolate, fullDup, speed100, anEn, colTest, rmii, repeater, edpd;
    assign nearLb = ctrl_ff[CTRL_LOOPBACK];
    assign speed100 = ctrl_ff[CTRL_SPEED100];
    assign anEn = ctrl_ff[CTRL_AN_ENABLE];
    assign isolate = ctrl_ff[CTRL_ISOLATE];
    assign fullDup = ctrl_ff[CTRL_FULL_DUPLEX];
    assign colTest = ctrl_ff[CTRL_COL_TEST];
    assign rmii = mode_ff[MODE_RMII];
    assign repeater = mode_ff[MODE_REPEATER];
    assign edpd = mode_ff[MODE_EDPD_ENABLE];
    assign remoteLb = mode_ff[MODE_REMOTE_LB] && rmii;

    // carrier detector on raw code bits
    phycl_cs_t cs_ff, nxt_cs;
    logic [9:0] win_ff;
    logic [3:0] ones_ff;
    logic [2:0] symCnt_ff;
    logic [4:0] prevSym_ff;
    logic [9:0] win;
    logic [4:0] sym;
    assign win = {win_ff[8:0], rxBitS};
    assign sym = win[4:0];

    always_comb begin
        nxt_cs = cs_ff;
        case (cs_ff)
            CS_IDLE: begin
                if (twoApartZeros(win)) begin
                    nxt_cs = CS_PRE;
                end
            end
            CS_PRE: begin
                if (win == CODE_JK) begin
                    nxt_cs = CS_STREAM;
                end else if (rxBitS && ones_ff == ONES_LIMIT - 4'h1) begin
                    nxt_cs = CS_IDLE;
                end
            end
            CS_STREAM: begin
                // end symbol or idle drops carrier
                if (symCnt_ff == SYM_LAST && (sym == CODE_T || sym == CODE_IDLE)) begin
                    nxt_cs = CS_ENDING;
                end
            end
            CS_ENDING: begin
                if (symCnt_ff == SYM_LAST) begin
                    if ((prevSym_ff == CODE_T && sym == CODE_R) ||
                        (prevSym_ff == CODE_IDLE && sym == CODE_IDLE)) begin
                        nxt_cs = CS_IDLE;
                    end else if (sym == CODE_T || sym == CODE_IDLE) begin
                        nxt_cs = CS_ENDING;
                    end else begin
                        nxt_cs = CS_STREAM;
                    end
                end
            end
            default: nxt_cs = CS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cs_ff <= CS_IDLE;
            win_ff <= 10'h3FF;
            ones_ff <= 4'h0;
            symCnt_ff <= 3'h0;
            prevSym_ff <= 5'h00;
        end else if (lineEdge) begin
            cs_ff <= nxt_cs;
            // flush so the end symbols' zeros cannot restart carrier
            win_ff <= (nxt_cs == CS_IDLE && cs_ff != CS_IDLE) ? 10'h3FF : win;
            ones_ff <= rxBitS ? ones_ff + 4'h1 : 4'h0;
            // symbols align to the bit after the start pair
            if (cs_ff == CS_PRE || symCnt_ff == SYM_LAST) begin
                symCnt_ff <= 3'h0;
            end else begin
                symCnt_ff <= symCnt_ff + 3'h1;
            end
            if (symCnt_ff == SYM_LAST) begin
                prevSym_ff <= sym;
            end
        end
    end

    logic lineCarrier;
    assign lineCarrier = cs_ff == CS_PRE || cs_ff == CS_STREAM;

    // link state machine
    phycl_link_t lk_ff, nxt_lk;
    logic [SETTLE_CNT_W-1:0] settle_ff;
    logic settleDone;
    assign settleDone = settle_ff >= SETTLE_CNT_W'(SETTLE_CYC - 1);

    always_comb begin
        nxt_lk = lk_ff;
        case (lk_ff)
            LK_DOWN: begin
                if (validS) begin
                    nxt_lk = LK_SETTLE;
                end
            end
            LK_SETTLE: begin
                if (!validS) begin
                    nxt_lk = LK_DOWN;
                end else if (settleDone) begin
                    nxt_lk = anEn ? LK_READY : LK_UP;
                end
            end
            LK_READY: begin
                if (!validS) begin
                    nxt_lk = LK_DOWN;
                end else if (grantS || !anEn) begin
                    nxt_lk = LK_UP;
                end
            end
            LK_UP: begin
                if (!validS) begin
                    nxt_lk = LK_DOWN;
                end
            end
            default: nxt_lk = LK_DOWN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || softReset) begin
            lk_ff <= LK_DOWN;
        end else begin
            lk_ff <= nxt_lk;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || softReset || lk_ff != LK_SETTLE) begin
            settle_ff <= '0;
        end else if (!settleDone) begin
            settle_ff <= settle_ff + SETTLE_CNT_W'(1);
        end
    end

    logic linkUp, linkStatus;
    assign linkUp = lk_ff == LK_UP && validS;
    assign linkStatus = speed100 ? linkUp : link10S;

    // activity and carrier
    logic txAct, rxAct, crsVal, colVal, macOff;
    assign txAct = txEnS && !isolate && !remoteLb;
    assign rxAct = nearLb ? txAct : (lineCarrier && (linkUp || !speed100));
    assign crsVal = (fullDup || repeater) ? rxAct : (rxAct || txAct);
    assign macOff = isolate || remoteLb;

    always_comb begin
        if (colTest) begin
            colVal = txAct;
        end else if (fullDup || nearLb) begin
            colVal = 1'b0;
        end else begin
            colVal = txAct && lineCarrier;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            crs <= 1'b0;
            crsDv <= 1'b0;
            col <= 1'b0;
            rxDv <= 1'b0;
            rxd <= 4'h0;
        end else begin
            crs <= crsVal && !rmii && !macOff;
            crsDv <= crsVal && rmii && !macOff;
            col <= colVal && !macOff;
            rxDv <= rxAct && !macOff;
            rxd <= macOff ? 4'h0 : (nearLb ? txdS : nibS2_ff);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lineTxBit <= 1'b0;
            lineTxEn <= 1'b0;
            txPowerDown <= 1'b1;
            linkIndicatorOutput <= 1'b0;
        end else begin
            lineTxBit <= remoteLb ? rxBitS : 1'b0;
            lineTxEn <= remoteLb || (txAct && !nearLb && linkUp);
            txPowerDown <= nearLb || (edpd && !validS);
            linkIndicatorOutput <= linkStatus;
        end
    end

    // apb answer one cycle after setup
    logic [15:0] rdVal;
    always_comb begin
        rdVal = 16'h0000;
        if (isCtrl) begin
            rdVal = ctrl_ff;
        end else if (isStat) begin
            rdVal = STAT_CONST_VAL;
            rdVal[STAT_LINK] = linkStatus;
        end else if (isMode) begin
            rdVal = mode_ff;
            rdVal[MODE_LINK_UP] = linkUp;
            rdVal[MODE_CARRIER] = crsVal;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (psel && !penable && !pwrite) ? {16'h0000, rdVal} : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ---- pkg/phycl_pkg.sv ----
`default_nettype none
package phycl_pkg;
    // clock and settling time
    localparam int CLK_PERIOD_NS = 40;
    localparam int SETTLE_TIME_NS = 330000;
    localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W = 14;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_BASIC_CTRL = 6'h00;
    localparam logic [5:0] IDX_BASIC_STAT = 6'h01;
    localparam logic [5:0] IDX_MODE_CTRL = 6'h11;

    // basic control fields
    localparam int CTRL_SOFT_RESET = 15;
    localparam int CTRL_LOOPBACK = 14;
    localparam int CTRL_SPEED100 = 13;
    localparam int CTRL_AN_ENABLE = 12;
    localparam int CTRL_ISOLATE = 10;
    localparam int CTRL_FULL_DUPLEX = 8;
    localparam int CTRL_COL_TEST = 7;
    localparam logic [15:0] CTRL_RESET_VAL = 16'h3000;
    localparam logic [15:0] CTRL_WR_MASK = 16'h7580;

    // basic status fields
    localparam int STAT_LINK = 2;
    localparam logic [15:0] STAT_CONST_VAL = 16'h7809;

    // mode control/status fields
    localparam int MODE_EDPD_ENABLE = 13;
    localparam int MODE_REMOTE_LB = 9;
    localparam int MODE_RMII = 5;
    localparam int MODE_REPEATER = 4;
    localparam int MODE_LINK_UP = 1;
    localparam int MODE_CARRIER = 0;
    localparam logic [15:0] MODE_RESET_VAL = 16'h0000;
    localparam logic [15:0] MODE_WR_MASK = 16'h2230;

    // code groups, first bit on the line in the msb
    localparam logic [9:0] CODE_JK = 10'h311;
    localparam logic [4:0] CODE_T = 5'h0D;
    localparam logic [4:0] CODE_R = 5'h07;
    localparam logic [4:0] CODE_IDLE = 5'h1F;
    localparam logic [3:0] ONES_LIMIT = 4'hA;
    localparam logic [2:0] SYM_LAST = 3'h4;

    typedef enum logic [3:0] {
        CS_IDLE = 4'b0001,
        CS_PRE = 4'b0010,
        CS_STREAM = 4'b0100,
        CS_ENDING = 4'b1000
    } phycl_cs_t;

    typedef enum logic [3:0] {
        LK_DOWN = 4'b0001,
        LK_SETTLE = 4'b0010,
        LK_READY = 4'b0100,
        LK_UP = 4'b1000
    } phycl_link_t;
endpackage
`default_nettype wire

// ---- tb/phy_carrier_link_loopback_test.sv ----
`default_nettype none
module phy_carrier_link_loopback_test;
    timeunit 1ns;
    timeprecision 1ps;
    import phycl_pkg::*;
    localparam int SET = 20;
    logic clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, errSeen, txEn = 1'h0, crs, crsDv, col, rxDv, lineClk, lineRxBit;
    logic [3:0] txd = 4'h0, rxd;
    logic lineTxBit, lineTxEn, txPowerDown, signalValid = 1'h0, anGrant = 1'h0, link10 = 1'h0, link;
    int mismatches = 0, checksDone = 0;
    always #20 clk = ~clk;
    phycl_top #(.SETTLE_CYC(SET)) u_phycl_top (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txEn(txEn), .txd(txd),
        .crs(crs), .crsDv(crsDv), .col(col), .rxDv(rxDv), .rxd(rxd), .lineClk(lineClk),
        .lineRxBit(lineRxBit), .lineRxNibble(4'h5), .lineTxBit(lineTxBit), .lineTxEn(lineTxEn),
        .txPowerDown(txPowerDown), .signalValid(signalValid), .anGrant(anGrant), .link10(link10),
        .linkIndicatorOutput(link)
    );
    phycl_line_model u_phycl_line_model (.lineClk(lineClk), .lineRxBit(lineRxBit));
    task automatic stop_test();
        if (mismatches == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        checksDone++;
        if (s !== x) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) begin
            mismatches++;
            stop_test();
        end
        rdv = prdata;
        errSeen = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk("read", rdv, x);
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic line(input logic [63:0] b, input int n);
        u_phycl_line_model.send(b, n);
        w(12);
    endtask
    initial begin
        #1000000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        rd(12'h000, 32'h3000);
        rd(12'h004, 32'h7809);
        rd(12'h044, 32'h0);
        rd(12'h100, 32'h0);
        chk("slverr", errSeen, 1'h1);
        wr(12'h004, 32'hFFFF);
        rd(12'h004, 32'h7809);
        wr(12'h000, 32'h8400);
        rd(12'h000, 32'h3000);
        // link bring-up with negotiation
        @(posedge clk) signalValid <= 1'h1;
        w(SET + 15);
        chk("link", link, 1'h0);
        @(posedge clk) anGrant <= 1'h1;
        w(8);
        chk("link", link, 1'h1);
        rd(12'h004, 32'h780D);
        @(posedge clk) signalValid <= 1'h0;
        w(5);
        chk("link", link, 1'h0);
        @(posedge clk) signalValid <= 1'h1;
        w(14);
        @(posedge clk) signalValid <= 1'h0;
        w(4);
        @(posedge clk) signalValid <= 1'h1;
        w(14);
        chk("link", link, 1'h0);
        w(SET + 8);
        chk("link", link, 1'h1);
        @(posedge clk) anGrant <= 1'h0;
        wr(12'h000, 32'h2000);
        @(posedge clk) signalValid <= 1'h0;
        w(4);
        @(posedge clk) signalValid <= 1'h1;
        w(SET + 10);
        chk("link", link, 1'h1);
        wr(12'h000, 32'h0);
        @(posedge clk) link10 <= 1'h1;
        w(6);
        chk("link", link, 1'h1);
        @(posedge clk) link10 <= 1'h0;
        w(6);
        chk("link", link, 1'h0);
        wr(12'h000, 32'h2000);
        w(6);
        chk("link", link, 1'h1);
        // carrier framing on the raw stream
        line({5'h1F, 10'h311, 5'h0E}, 20);
        chk("crs", crs, 1'h1);
        line({5'h1F, 5'h15}, 10);
        chk("crs", crs, 1'h1);
        line({5'h0D, 5'h0E}, 10);
        chk("crs", crs, 1'h1);
        @(posedge clk) txEn <= 1'h1;
        w(10);
        chk("col", col, 1'h1);
        @(posedge clk) txEn <= 1'h0;
        w(10);
        chk("col", col, 1'h0);
        line({5'h0D, 5'h07}, 10);
        chk("crs", crs, 1'h0);
        line(5'h1F, 5);
        chk("crs", crs, 1'h0);
        line({5'h1F, 10'h311, 5'h0E, 10'h3FF}, 30);
        chk("crs", crs, 1'h0);
        line(8'hF5, 8);
        chk("crs", crs, 1'h1);
        line(14'h3FFF, 14);
        chk("crs", crs, 1'h0);
        // transmit side carrier and collision test
        @(posedge clk) txEn <= 1'h1;
        w(8);
        chk("crs", crs, 1'h1);
        chk("ltxen", lineTxEn, 1'h1);
        wr(12'h000, 32'h2100);
        w(8);
        chk("crs", crs, 1'h0);
        chk("col", col, 1'h0);
        wr(12'h000, 32'h2000);
        wr(12'h044, 32'h0010);
        w(8);
        chk("crs", crs, 1'h0);
        wr(12'h044, 32'h0);
        wr(12'h000, 32'h2400);
        w(8);
        chk("crs", crs, 1'h0);
        rd(12'h000, 32'h2400);
        @(posedge clk) txEn <= 1'h0;
        wr(12'h000, 32'h2080);
        @(posedge clk) txEn <= 1'h1;
        w(8);
        chk("col", col, 1'h1);
        @(posedge clk) txEn <= 1'h0;
        w(8);
        chk("col", col, 1'h0);
        // near loopback
        wr(12'h000, 32'h6000);
        @(posedge clk) txd <= 4'hA;
        txEn <= 1'h1;
        w(8);
        chk("rxd", rxd, 4'hA);
        chk("pwrdn", txPowerDown, 1'h1);
        chk("col", col, 1'h0);
        chk("ltxen", lineTxEn, 1'h0);
        wr(12'h000, 32'h6080);
        w(8);
        chk("col", col, 1'h1);
        @(posedge clk) txEn <= 1'h0;
        // reduced pin mode and remote loopback
        wr(12'h000, 32'h2000);
        wr(12'h044, 32'h0020);
        line({5'h1F, 10'h311, 5'h0E}, 20);
        chk("crsdv", crsDv, 1'h1);
        chk("crs", crs, 1'h0);
        wr(12'h044, 32'h0220);
        w(6);
        chk("rxdv", rxDv, 1'h0);
        chk("ltxen", lineTxEn, 1'h1);
        line({5'h0D, 5'h06}, 10);
        chk("ltxbit", lineTxBit, 1'h1);
        stop_test();
    end
endmodule
`default_nettype wire

// ---- tb/phycl_line_model.sv ----
`default_nettype none
module phycl_line_model (
    // line stream toward the block
    output logic lineClk,
    output logic lineRxBit
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        lineClk = 1'h0;
        lineRxBit = 1'h1;
    end
    // clock runs only inside a burst
    task automatic send(input logic [63:0] b, input int n);
        // raw code bits, first bit first
        for (int i = n - 1; i >= 0; i--) begin
            lineRxBit <= b[i];
            #160 lineClk <= 1'h1;
            #160 lineClk <= 1'h0;
        end
        // stale data would hide a sampling slip
        lineRxBit <= ~lineRxBit;
    endtask
endmodule
`default_nettype wire

// ---- tb/phycl_top_sva.sv ----
`default_nettype none
module phycl_top_sva
    import phycl_pkg::*;
#(
    parameter int SETTLE_CYC = SETTLE_CYCLES
) (
    // system
    input wire logic clk,
    input wire logic reset,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // mac and line
    input wire logic txEn,
    input wire logic crs,
    input wire logic crsDv,
    input wire logic col,
    input wire logic rxDv,
    input wire logic lineTxBit,
    input wire logic txPowerDown,
    input wire logic signalValid,
    input wire logic linkIndicatorOutput
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_CTRL = {4'h0, IDX_BASIC_CTRL, 2'h0};
    localparam logic [11:0] A_MODE = {4'h0, IDX_MODE_CTRL, 2'h0};
    logic [15:0] ctrlShadow_ff;
    logic [15:0] modeShadow_ff;
    logic [15:0] validRun_ff;
    wire logic wrDone = psel && penable && pready && pwrite;
    wire logic ct = ctrlShadow_ff[CTRL_COL_TEST];
    wire logic rmii = modeShadow_ff[MODE_RMII];
    wire logic fast = ctrlShadow_ff[CTRL_SPEED100];
    // isolate or remote loop hides transmit enable from the collision logic
    wire logic macOn = !ctrlShadow_ff[CTRL_ISOLATE] && !(modeShadow_ff[MODE_REMOTE_LB] && rmii);
    // shadow copies, since only the pins are visible here
    always_ff @(posedge clk) begin
        if (reset || (wrDone && paddr == A_CTRL && pwdata[CTRL_SOFT_RESET])) begin
            ctrlShadow_ff <= CTRL_RESET_VAL;
            modeShadow_ff <= MODE_RESET_VAL;
        end else if (wrDone && paddr == A_CTRL) begin
            ctrlShadow_ff <= pwdata[15:0] & CTRL_WR_MASK;
        end else if (wrDone && paddr == A_MODE) begin
            modeShadow_ff <= pwdata[15:0] & MODE_WR_MASK;
        end
    end
    // saturates so a long valid period cannot wrap
    always_ff @(posedge clk) begin
        if (reset || !signalValid) begin
            validRun_ff <= 16'h0;
        end else if (validRun_ff != 16'hFFFF) begin
            validRun_ff <= validRun_ff + 16'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable && pready;
    endsequence
    apb_answer_a: assert property (setupS |=> pready)
        else $error("apb answer missing");
    apb_single_a: assert property (accessS |=> !pready)
        else $error("apb ready held");
    unmapped_err_a: assert property ((accessS and (paddr[11:8] != 4'h0)) |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    ctrl_read_a: assert property ((accessS and (!pwrite && paddr == A_CTRL)) |-> prdata == {16'h0, ctrlShadow_ff})
        else $error("control readback wrong");
    pin_select_a: assert property ($stable(modeShadow_ff)[*3] |-> (rmii ? !crs : !crsDv))
        else $error("carrier on wrong pin");
    fd_nocol_a: assert property ((ctrlShadow_ff[CTRL_FULL_DUPLEX] && !ct)[*4] |-> !col)
        else $error("collision in full duplex");
    coltest_rise_a: assert property (ct && macOn && $rose(txEn) |-> ##[1:8] col)
        else $error("collision test late");
    coltest_fall_a: assert property (ct && $fell(txEn) |-> ##[1:6] !col)
        else $error("collision test stuck");
    link_drop_a: assert property (fast && $fell(signalValid) |-> ##[1:5] !linkIndicatorOutput)
        else $error("link held after valid loss");
    settle_min_a: assert property (fast && $rose(linkIndicatorOutput) |-> int'(validRun_ff) >= SETTLE_CYC)
        else $error("link up before settling");
    near_loop_a: assert property ((ctrlShadow_ff[CTRL_LOOPBACK] && !ct)[*4] |-> !col && txPowerDown)
        else $error("near loopback outputs wrong");
    remote_gate_a: assert property ((!(modeShadow_ff[MODE_REMOTE_LB] && rmii))[*4] |-> !lineTxBit)
        else $error("line echo without remote loopback");
    remote_iso_a: assert property ((modeShadow_ff[MODE_REMOTE_LB] && rmii)[*4] |-> !rxDv)
        else $error("mac not isolated");
endmodule
bind phycl_top phycl_top_sva #(.SETTLE_CYC(SETTLE_CYC)) u_phycl_top_sva (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txEn(txEn), .crs(crs),
    .crsDv(crsDv), .col(col), .rxDv(rxDv), .lineTxBit(lineTxBit), .txPowerDown(txPowerDown),
    .signalValid(signalValid), .linkIndicatorOutput(linkIndicatorOutput)
);
`default_nettype wire
